// file: logic/adc_readout_pkg.sv
// constants, timing counts and mode encoding shared by the converter readout block
// assumes a single 40 MHz reference clock for all counts below

package adc_readout_pkg;

    // ------------------------------------------------------------
    // widths and depths
    // ------------------------------------------------------------
    localparam int RESULT_BITS = 14;
    localparam int FRAME_BITS  = 16;
    localparam int FIFO_DEPTH  = 8;
    localparam int TIMER_BITS  = 9;
    localparam int COUNT_BITS  = 5;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 25000;
    localparam int CONV_TIME_NS  = 5000;
    localparam int WAKE_TIME_NS  = 5000;
    // longest times, so round down
    localparam int CONV_CYCLES   = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int WAKE_CYCLES   = (WAKE_TIME_NS * 1000) / CLK_PERIOD_PS;

    // ------------------------------------------------------------
    // reset values, frame positions and mode encoding
    // ------------------------------------------------------------
    localparam logic START_IDLE     = 1'h1;
    localparam logic SCLK_IDLE      = 1'h0;
    localparam int   LAST_FALL      = 15;
    localparam int   MSB_FALL       = 1;
    localparam int   LSB_FALL       = 14;

    typedef enum logic [1:0] {
        MODE_TRACK   = 2'b00,
        MODE_CONVERT = 2'b01,
        MODE_SLEEP   = 2'b10,
        MODE_WAKE    = 2'b11
    } mode_t;

endpackage

// file: logic/pin_sync.sv
// two-flop synchroniser for a group of pin levels
// assumes inputs are asynchronous to ref_clk; outputs are levels only
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] reset_val,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    // reset_val is tied to constants by the parent
    always_comb begin
        next_st        = st;
        next_st.stage1 = pin_in;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st.stage1 <= reset_val;
            st.stage2 <= reset_val;
        end else begin
            st <= next_st;
        end
    end

    assign pin_sync_out = st.stage2;
endmodule

`default_nettype wire

// file: logic/result_fifo.sv
// result fifo between converter and output register
// assumes both sides on ref_clk; writer stalls on in_ready low
`timescale 1ns/1ps
`default_nettype none

module result_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 fill;
    } fifo_state_t;

    fifo_state_t st;
    fifo_state_t next_st;
    logic        do_push;
    logic        do_pop;

    assign in_ready  = (st.fill != (AW+1)'(DEPTH));
    assign out_valid = (st.fill != '0);
    assign out_data  = st.mem[st.rd];
    assign do_push   = in_valid & in_ready;
    assign do_pop    = out_valid & out_ready;

    always_comb begin
        next_st = st;
        if (do_push) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + AW'(1);
        end
        if (do_pop) begin
            next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + AW'(1);
        end
        if (do_push && !do_pop) begin
            next_st.fill = st.fill + (AW+1)'(1);
        end else if (do_pop && !do_push) begin
            next_st.fill = st.fill - (AW+1)'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

`default_nettype wire

// file: logic/adc_conversion_serial_readout.sv
// conversion control, auto sleep and serial readout of a 14-bit converter
// assumes start strobe and shift clock are async pins, sampled at 40 MHz;
// sample_code and range_bipolar come from on-chip logic on ref_clk
//
// What this block does, and what the host must do
// (RQ1) start fall holds, raises busy, converts within 5us
// (RQ2) start low at busy fall enters sleep
// (RQ3) start rise wakes; one-shot timer of 5us
// (RQ4) sleep: hold 5us after waking rise
// (RQ5) host: sleep pulse 40ns-2us or over 6us
// (RQ6) long pulse: conversion ends 5us after fall
// (RQ7) result readable while asleep, same frame
// (RQ8) host: read ends 250ns before next start
// (RQ9) shift clock at most 16 MHz
// (RQ10) data changes on shift clock falling edges
// (RQ11) first zero driven on first rising edge
// (RQ12) frame: two zeros then result, msb first
// (RQ13) lsb held past 16th fall, then released
// (RQ14) host: shift clock low after sixteenth bit
// (RQ15) extra clocks restart frame, output stays driven
// (RQ16) start fall resets counter if clock low
// (RQ17) host: shift clock low across conversion
// (RQ18) conversion end: busy low, result loaded
// (RQ19) shift clock may pause between bytes
// (RQ20) host is master, may skip busy
// (RQ21) host gates clock with select line
// (RQ22) host spi port: polarity 0, phase 1
// (RQ23) bipolar twos complement, unipolar straight binary
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_serial_readout
    import adc_readout_pkg::*;
#(
    parameter int CONV_CYC = CONV_CYCLES,
    parameter int WAKE_CYC = WAKE_CYCLES,
    parameter int DEPTH    = FIFO_DEPTH
) (
    input  wire logic                   ref_clk,
    input  wire logic                   resetn,
    input  wire logic                   conversion_start_n,
    input  wire logic                   read_shift_clock,
    input  wire logic [RESULT_BITS-1:0] sample_code,
    input  wire logic                   range_bipolar,
    output logic                        busy,
    output logic                        track_hold,
    output logic                        sleeping,
    output logic                        serial_out_line,
    output logic                        serial_out_en
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        mode_t                  mode;
        logic [TIMER_BITS-1:0]  timer;
        logic                   start_q;
        logic                   sclk_q;
        logic                   pending;
        logic                   busy;
        logic                   hold;
        logic                   sleep;
        logic                   push_valid;
        logic [RESULT_BITS-1:0] push_data;
        logic [RESULT_BITS-1:0] out_reg;
        logic [FRAME_BITS-1:0]  shift;
        logic [COUNT_BITS-1:0]  count;
        logic                   done_once;
        logic                   keep_driven;
        logic                   sdo;
        logic                   sdo_en;
    } ctrl_state_t;

    ctrl_state_t st;
    ctrl_state_t next_st;

    logic [1:0]             pins_s;
    logic                   start_s;
    logic                   sclk_s;
    logic                   start_fall;
    logic                   start_rise;
    logic                   sclk_fall;
    logic                   sclk_rise;
    logic                   fifo_in_ready;
    logic                   fifo_out_valid;
    logic                   fifo_out_ready;
    logic [RESULT_BITS-1:0] fifo_out_data;
    logic                   push_done;

    localparam logic [TIMER_BITS-1:0] CONV_LOAD = TIMER_BITS'(CONV_CYC - 1);
    localparam logic [TIMER_BITS-1:0] WAKE_LOAD = TIMER_BITS'(WAKE_CYC - 1);

    // ------------------------------------------------------------
    // pin sampling and edges
    // ------------------------------------------------------------
    // limitation: each shift clock level must span at least one ref_clk edge, which bounds its rate
    pin_sync #(
        .WIDTH (2)
    ) u_sync (
        .ref_clk      (ref_clk),
        .resetn       (resetn),
        .reset_val    ({START_IDLE, SCLK_IDLE}),
        .pin_in       ({conversion_start_n, read_shift_clock}),   // RQ9
        .pin_sync_out (pins_s)
    );

    assign start_s    = pins_s[1];
    assign sclk_s     = pins_s[0];
    assign start_fall = st.start_q & ~start_s;
    assign start_rise = ~st.start_q & start_s;
    assign sclk_fall  = st.sclk_q & ~sclk_s;
    assign sclk_rise  = ~st.sclk_q & sclk_s;
    assign push_done  = st.push_valid & fifo_in_ready;

    // ------------------------------------------------------------
    // result buffer
    // ------------------------------------------------------------
    // output register only reloads between frames, so a slow read stalls the fifo
    assign fifo_out_ready = (st.count == '0) & ~sclk_s;

    result_fifo #(
        .WIDTH (RESULT_BITS),
        .DEPTH (DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .in_valid  (st.push_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (st.push_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st         = st;
        next_st.start_q = start_s;
        next_st.sclk_q  = sclk_s;
        if (st.timer != '0) begin
            next_st.timer = st.timer - TIMER_BITS'(1);
        end
        case (st.mode)
            MODE_TRACK: begin
                if (start_fall) begin
                    next_st.mode  = MODE_CONVERT;   // RQ1
                    next_st.busy  = 1'b1;           // RQ1
                    next_st.hold  = 1'b1;           // RQ1
                    next_st.timer = CONV_LOAD;      // RQ6
                end
            end
            MODE_CONVERT: begin
                if (st.timer == '0 && !st.push_valid) begin
                    next_st.push_valid = 1'b1;
                    // unipolar code passes straight; bipolar flips the msb
                    next_st.push_data  = {sample_code[RESULT_BITS-1] ^ range_bipolar,
                                          sample_code[RESULT_BITS-2:0]};   // RQ23
                end
                // a full fifo holds busy high until a word drains
                if (push_done) begin
                    next_st.push_valid = 1'b0;
                    next_st.busy       = 1'b0;                              // RQ18
                    next_st.hold       = 1'b0;
                    next_st.pending    = 1'b0;
                    next_st.sleep      = ~start_s;                          // RQ2
                    next_st.mode       = start_s ? MODE_TRACK : MODE_SLEEP; // RQ2
                end
            end
            MODE_SLEEP: begin
                if (start_rise) begin
                    next_st.mode    = MODE_WAKE;    // RQ3
                    next_st.timer   = WAKE_LOAD;    // RQ3
                    next_st.pending = 1'b0;
                end
            end
            MODE_WAKE: begin
                if (start_fall) begin
                    next_st.pending = 1'b1;
                    next_st.busy    = 1'b1;         // RQ1
                end
                if (st.timer == '0) begin
                    next_st.sleep = 1'b0;
                    if (st.pending || start_fall) begin
                        next_st.mode  = MODE_CONVERT;   // RQ4
                        next_st.hold  = 1'b1;           // RQ4
                        next_st.busy  = 1'b1;
                        next_st.timer = CONV_LOAD;
                    end else begin
                        // long pulse: awake, next fall converts as usual
                        next_st.mode = MODE_TRACK;      // RQ6
                    end
                end
            end
            default: begin
                next_st.mode = MODE_TRACK;
            end
        endcase

        // serial side runs in every mode, sleep included (RQ7, RQ19)
        if (sclk_rise && st.count == '0) begin
            next_st.shift  = {2'h0, st.out_reg};   // RQ12
            next_st.sdo    = 1'b0;                 // RQ11
            next_st.sdo_en = 1'b1;                 // RQ11
            if (st.done_once) begin
                next_st.keep_driven = 1'b1;        // RQ15
            end
        end else if (sclk_fall) begin
            next_st.shift = {st.shift[FRAME_BITS-2:0], 1'b0};   // RQ10
            if (st.count == COUNT_BITS'(LAST_FALL)) begin
                // lsb stays on the line past the last fall
                next_st.count     = '0;            // RQ13
                next_st.done_once = 1'b1;
                next_st.sdo_en    = st.keep_driven;   // RQ13
            end else begin
                next_st.sdo   = st.shift[FRAME_BITS-2];   // RQ10
                next_st.count = st.count + COUNT_BITS'(1);
            end
        end
        if (fifo_out_valid && fifo_out_ready) begin
            next_st.out_reg = fifo_out_data;       // RQ18
        end
        // a start edge with the clock high leaves the frame alone
        if (start_fall && !sclk_s) begin
            next_st.count       = '0;              // RQ16
            next_st.shift       = '0;              // RQ16
            next_st.sdo         = 1'b0;
            next_st.sdo_en      = 1'b0;
            next_st.done_once   = 1'b0;
            next_st.keep_driven = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st         <= '0;
            st.mode    <= MODE_TRACK;
            st.start_q <= START_IDLE;
            st.sclk_q  <= SCLK_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign busy            = st.busy;
    assign track_hold      = st.hold;
    assign sleeping        = st.sleep;
    assign serial_out_line = st.sdo;
    assign serial_out_en   = st.sdo_en;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    localparam int CONV_WIN = 210;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    start_hold_busy_a: assert property ( // RQ1
        (st.mode == MODE_TRACK) && start_fall |=> st.hold && st.busy)
        else $error("start fall did not hold and raise busy");

    busy_bound_a: assert property ( // RQ1
        $rose(st.busy) && $past(st.mode) == MODE_TRACK
        |-> ##[1:CONV_WIN] (!st.busy || !fifo_in_ready))
        else $error("busy stayed high past conversion time");

    sleep_entry_a: assert property ( // RQ2
        push_done && !start_s |=> st.sleep && st.mode == MODE_SLEEP && !st.busy)
        else $error("low start at busy fall did not enter sleep");

    stay_awake_a: assert property ( // RQ2
        push_done && start_s |=> !st.sleep && st.mode == MODE_TRACK)
        else $error("high start at busy fall entered sleep");

    wake_timer_a: assert property ( // RQ3
        st.mode == MODE_SLEEP && start_rise |=> st.mode == MODE_WAKE && st.timer == WAKE_LOAD)
        else $error("wake timer not started on start rise");

    wake_hold_a: assert property ( // RQ4
        st.mode == MODE_WAKE && st.timer == '0 && st.pending
        |=> st.hold && st.mode == MODE_CONVERT && $past(st.hold) == 1'b0)
        else $error("hold not taken at end of wake time");

    first_zero_a: assert property ( // RQ11
        sclk_rise && st.count == '0 && !start_fall |=> st.sdo_en && !st.sdo)
        else $error("first zero not driven on first rise");

    msb_bit_a: assert property ( // RQ12
        sclk_fall && st.count == COUNT_BITS'(MSB_FALL) && !start_fall
        |=> st.sdo == st.shift[FRAME_BITS-1] && st.sdo == $past(st.shift[FRAME_BITS-2]))
        else $error("msb not presented after second fall");

    lsb_release_a: assert property ( // RQ13
        sclk_fall && st.count == COUNT_BITS'(LAST_FALL) && !st.keep_driven && !start_fall
        |=> !st.sdo_en && st.sdo == $past(st.sdo))
        else $error("line not released after 16th fall");

    extra_driven_a: assert property ( // RQ15
        st.keep_driven && !start_fall |=> st.sdo_en)
        else $error("output released after extra clocks");

    counter_reset_a: assert property ( // RQ16
        start_fall && !sclk_s |=> st.count == '0 && !st.sdo_en && !st.keep_driven)
        else $error("start fall did not reset serial counter");

    result_load_a: assert property ( // RQ18
        push_done && !fifo_out_valid
        |=> !st.busy ##1 (st.out_reg == $past(st.push_data, 2) || !$past(fifo_out_ready)))
        else $error("result not loaded at conversion end");

    cover_sleep_cycle: cover property (
        st.mode == MODE_SLEEP ##[1:1000] st.mode == MODE_WAKE ##[1:300] st.mode == MODE_CONVERT);
    cover_long_pulse: cover property (
        st.mode == MODE_WAKE ##1 st.mode == MODE_TRACK);
    cover_extra_clocks: cover property (st.keep_driven && st.sdo_en);
    cover_fifo_full: cover property (st.push_valid && !fifo_in_ready);
endmodule

`default_nettype wire

// file: verif/host_master.sv
// host serial master model: drives the shift clock and samples the data line
// assumes the data line settles within 100 ns of a shift clock fall
`timescale 1ns/1ps
`default_nettype none

module host_master (
    input  wire logic        serial_out_line,
    input  wire logic        serial_out_en,
    output logic             read_shift_clock,
    output logic [15:0]      frame_word,
    output logic             frame_done
);
    logic last_bit;
    logic host_clk;
    logic dev_select;

    // the device sees the host clock only while its select line is high
    assign read_shift_clock = host_clk & dev_select;

    initial begin
        host_clk         = 1'b0;
        dev_select       = 1'b0;
        frame_word       = 16'h0000;
        frame_done       = 1'b0;
        last_bit         = 1'b0;
    end

    // a released line reads as the inverse of the last bit, so a float never looks right
    function automatic logic line_level();
        return serial_out_en ? serial_out_line : ~last_bit;
    endfunction

    // ------------------------------------------------------------
    // frame read
    // ------------------------------------------------------------
    // 200 ns period, idle low, sampled just before each fall (polarity 0, phase 1)
    // edges stay 2 ns after a ref_clk rise, like the rest of the stimulus
    task automatic read_frame(input logic split);
        logic [15:0] w;
        w = 16'h0000;
        dev_select = 1'b1;
        #25;
        for (int i = 0; i < 16; i++) begin
            host_clk = 1'b1;
            #125;
            last_bit = line_level();
            w = {w[14:0], last_bit};
            host_clk = 1'b0;
            #75;
            if (split && i == 7) begin
                #1000;
            end
        end
        dev_select = 1'b0;
        frame_word = w;
        frame_done = 1'b1;
        #1;
        frame_done = 1'b0;
    endtask

    task automatic pulses(input int n);
        dev_select = 1'b1;
        for (int i = 0; i < n; i++) begin
            host_clk = 1'b1;
            #125;
            host_clk = 1'b0;
            #75;
        end
        dev_select = 1'b0;
    endtask

    // used to stall the output register on purpose, and with the clock low to end the stall
    task automatic hold_level(input logic lvl);
        dev_select = 1'b1;
        host_clk = lvl;
    endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench for the converter control and serial readout block
// assumes the host model drives the shift clock; start strobe and codes come from here
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import adc_readout_pkg::*;

    localparam int CC = 20;
    localparam int WC = 20;

    logic                   ref_clk = 1'b0;
    logic                   resetn = 1'b0;
    logic                   conversion_start_n = 1'b1;
    logic [RESULT_BITS-1:0] sample_code = '0;
    logic                   range_bipolar = 1'b0;
    logic                   busy;
    logic                   track_hold;
    logic                   sleeping;
    logic                   serial_out_line;
    logic                   serial_out_en;
    logic                   read_shift_clock;
    logic [15:0]            frame_word;
    logic                   frame_done;
    int                     err_total = 0;
    int                     checks_done = 0;
    int                     seed = 32'h48B4866E;
    int                     blen;
    logic [15:0]            exp_q[$];

    always #12.5 ref_clk = ~ref_clk;

    adc_conversion_serial_readout #(.CONV_CYC(CC), .WAKE_CYC(WC), .DEPTH(FIFO_DEPTH)) uut (
        .ref_clk(ref_clk), .resetn(resetn), .conversion_start_n(conversion_start_n),
        .read_shift_clock(read_shift_clock), .sample_code(sample_code),
        .range_bipolar(range_bipolar), .busy(busy), .track_hold(track_hold),
        .sleeping(sleeping), .serial_out_line(serial_out_line), .serial_out_en(serial_out_en)
    );

    host_master host (
        .serial_out_line(serial_out_line), .serial_out_en(serial_out_en),
        .read_shift_clock(read_shift_clock), .frame_word(frame_word), .frame_done(frame_done)
    );

    // ------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------
    task automatic end_of_test();
        if (err_total == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask

    task automatic rng(input string nm, input int lo, input int hi, input int n);
        checks_done++;
        if (n < lo || n > hi) begin
            $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, n);
            err_total++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask

    function automatic logic sig(input int s);
        return (s == 0) ? busy : (s == 1) ? track_hold : sleeping;
    endfunction

    // bounded wait, so a stuck output shows as a count far out of range
    task automatic wait_for(input int s, input logic lvl, output int n);
        n = 0;
        while (n < 2000 && sig(s) !== lvl) begin
            tick(1);
            n++;
        end
    endtask

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    // one conversion; wake_high > 0 means waking from sleep first
    task automatic conv(input logic stay_low, input int wake_high, input logic keep);
        int n;
        sample_code = RESULT_BITS'($random(seed));
        if (keep) begin
            exp_q.push_back({2'b00, sample_code ^ {range_bipolar, 13'h0000}});
        end
        if (wake_high != 0) begin
            conversion_start_n = 1'b1;
            tick(wake_high);
            chk("waking", {15'h0000, wake_high < WC}, {15'h0000, sleeping});
        end
        // start goes back high unless this conversion should end in sleep
        conversion_start_n = 1'b0;
        tick(2);
        if (!stay_low) begin
            conversion_start_n = 1'b1;
        end
        wait_for(1, 1'b1, n);
        if (wake_high == 0) begin
            rng("hold_rise", 1, 3, n);
        end else if (wake_high < WC) begin
            rng("hold_after_wake", WC + 2, WC + 6, wake_high + n + 2);
        end else begin
            rng("hold_long_pulse", 3, 5, n + 2);
        end
        chk("busy_with_hold", 16'h0001, {15'h0000, busy});
        if (keep) begin
            wait_for(0, 1'b0, n);
            rng("busy_length", CC, CC + 2, n);
            chk("track_after", 16'h0000, {15'h0000, track_hold});
            tick(1);
            chk("sleep_entry", {15'h0000, stay_low}, {15'h0000, sleeping});
        end
    endtask

    task automatic rd(input logic split);
        host.read_frame(split);
        tick(8);
        chk("released", 16'h0000, {15'h0000, serial_out_en});
        tick(4);
    endtask

    // the oldest expected frame is matched to each frame the host completes
    always @(posedge frame_done) begin
        if (exp_q.size() == 0) begin
            chk("frame_unexpected", 16'h0001, 16'(exp_q.size()));
        end else begin
            chk("frame", exp_q.pop_front(), frame_word);
        end
    end

    initial begin
        #(20000 * 25);
        err_total++;
        end_of_test();
    end

    initial begin
        tick(4);
        resetn = 1'b1;
        tick(4);
        for (int i = 0; i < 4; i++) begin
            range_bipolar = i[0];
            conv(1'b0, 0, 1'b1);
            rd(i == 1);
        end
        host.pulses(18);
        tick(8);
        chk("kept_driven", 16'h0001, {15'h0000, serial_out_en});
        conv(1'b0, 0, 1'b1);
        chk("counter_cleared", 16'h0000, {15'h0000, serial_out_en});
        rd(1'b0);
        conv(1'b1, 0, 1'b1);
        rd(1'b0);
        chk("still_asleep", 16'h0001, {15'h0000, sleeping});
        conv(1'b1, 4, 1'b1);
        rd(1'b0);
        conv(1'b0, 2 * WC, 1'b1);
        rd(1'b0);
        // fifo fill: the clock held high stops the output register taking new results
        host.hold_level(1'b1);
        tick(2);
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            conv(1'b0, 0, 1'b0);
            tick(CC + 8);
        end
        conv(1'b0, 0, 1'b0);
        tick(CC + 10);
        chk("busy_stalled", 16'h0001, {15'h0000, busy});
        resetn = 1'b0;
        host.hold_level(1'b0);
        tick(4);
        resetn = 1'b1;
        tick(4);
        chk("reset_busy", 16'h0000, {15'h0000, busy});
        chk("reset_en", 16'h0000, {15'h0000, serial_out_en});
        conv(1'b0, 0, 1'b1);
        rd(1'b0);
        chk("pending", 16'h0000, 16'(exp_q.size()));
        end_of_test();
    end
endmodule
`default_nettype wire
